// ---- design/dscd_cfg.svh ----
// Constants for the serial command decoder: timing, status and configuration fields
`ifndef DSCD_CFG_SVH
`define DSCD_CFG_SVH
`define CLK_HZ 50000000
`define RECAL_MS 100
`define TRACK_OFS_MS 3
`define POWERUP_S 35
`define SEEK_CYCLES_DEF 1000
`define WORD_BITS 17
`define BYTES_PER_TRACK 16'h5190
`define BPS_MIN 12'h052
`define ISG_WORD 16'h0C10
`define SYNC_WORD 16'h000B
`define VU_COUNT_WORD 16'h000F
`define ST_INVALID 0
`define ST_PARITY 1
`define ST_VU_AVAIL 2
`define ST_DIAG 3
`define ST_SPIN_STOP 12
`define ST_CLEAR_MASK 16'h0FFF
`define GEN_CFG_BASE 16'h3248
`define GEN_MOTOR_BIT 5
`define GEN_SOFT_BIT 2
`define GEN_HARD_BIT 1
`define SOFT_SW_NUM 4'h1
`define CTL_RESET_ATT 4'h0
`define CTL_START_MOTOR 4'h3
`define CFG_BAD_LO 4'hA
`define CFG_BAD_HI 4'hE
`endif

// ---- design/dscd_pkg.sv ----
// Types shared by the serial command decoder modules
package dscd_pkg;
  typedef enum logic [3:0] {
    CMD_SEEK = 4'h0, CMD_RECAL = 4'h1, CMD_STATUS = 4'h2, CMD_CONFIG = 4'h3,
    CMD_HEAD_GROUP = 4'h4, CMD_CONTROL = 4'h5, CMD_STROBE_OFS = 4'h6, CMD_TRACK_OFS = 4'h7,
    CMD_DIAG = 4'h8, CMD_SET_BPS = 4'h9, CMD_SET_CFG = 4'hE
  } cmd_code_t;
  typedef enum logic [4:0] {
    ST_POWERUP = 5'h01, ST_IDLE = 5'h02, ST_EXEC = 5'h04, ST_SEND = 5'h08, ST_DIVIDE = 5'h10
  } state_t;
endpackage

// ---- design/cmd_shift_if.sv ----
// Carrier between the serial shifter and the command core
`timescale 1ns/1ps
interface cmd_shift_if;
  logic word_valid;
  logic [15:0] word;
  logic parity_ok;
  logic resp_load;
  logic [15:0] resp_word;
  logic tx_done;
  modport rx (output word_valid, word, parity_ok, tx_done, input resp_load, resp_word);
  modport core (input word_valid, word, parity_ok, tx_done, output resp_load, resp_word);
endinterface

// ---- design/cmd_word_receiver.sv ----
// Serial request/acknowledge shifter for command words and response words
`timescale 1ns/1ps
`include "dscd_cfg.svh"
module cmd_word_receiver
  import dscd_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Serial pins
  input wire logic transfer_req,
  input wire logic command_data,
  output logic transfer_ack,
  output logic config_status,
  // Core side
  cmd_shift_if.rx lnk
);
  logic [2:0] req_sync_reg;
  logic [2:0] dat_sync_reg;
  logic req_level_reg;
  logic [16:0] rx_sr_reg;
  logic [4:0] rx_cnt_reg;
  logic [16:0] tx_sr_reg;
  logic [4:0] tx_cnt_reg;
  logic req_edge;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_sync_reg <= 3'h0;
      dat_sync_reg <= 3'h0;
    end
    else
    begin
      req_sync_reg <= {req_sync_reg[1:0], transfer_req};
      dat_sync_reg <= {dat_sync_reg[1:0], command_data};
    end
  end

  // A request change counts only once the second and third stages agree
  assign req_edge = (req_sync_reg[1] == req_sync_reg[2]) && (req_sync_reg[2] != req_level_reg);

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_level_reg <= 1'b0;
      transfer_ack <= 1'b0;
    end
    else if (req_edge)
    begin
      req_level_reg <= req_sync_reg[2];
      transfer_ack <= req_sync_reg[2];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_sr_reg <= 17'h00000;
      rx_cnt_reg <= 5'h00;
      lnk.word_valid <= 1'b0;
      lnk.word <= 16'h0000;
      lnk.parity_ok <= 1'b0;
    end
    else
    begin
      lnk.word_valid <= 1'b0;
      if (req_edge && tx_cnt_reg == 5'h00)
      begin
        rx_sr_reg <= {rx_sr_reg[15:0], dat_sync_reg[2]};
        if (rx_cnt_reg == 5'(`WORD_BITS - 1))
        begin
          // Odd parity over sixteen data bits and the parity bit
          lnk.word_valid <= 1'b1;
          lnk.word <= rx_sr_reg[15:0];
          lnk.parity_ok <= ^{rx_sr_reg[15:0], dat_sync_reg[2]};
          rx_cnt_reg <= 5'h00;
        end
        else
          rx_cnt_reg <= rx_cnt_reg + 5'h01;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_sr_reg <= 17'h00000;
      tx_cnt_reg <= 5'h00;
      config_status <= 1'b0;
      lnk.tx_done <= 1'b0;
    end
    else
    begin
      lnk.tx_done <= 1'b0;
      if (lnk.resp_load)
      begin
        tx_sr_reg <= {lnk.resp_word, ~^lnk.resp_word};
        tx_cnt_reg <= 5'(`WORD_BITS);
      end
      else if (req_edge && tx_cnt_reg != 5'h00)
      begin
        // Bit goes out in the same cycle the acknowledge toggles
        config_status <= tx_sr_reg[16];
        tx_sr_reg <= {tx_sr_reg[15:0], 1'b0};
        tx_cnt_reg <= tx_cnt_reg - 5'h01;
        lnk.tx_done <= (tx_cnt_reg == 5'h01);
      end
    end
  end
endmodule // cmd_word_receiver

// ---- design/disk_serial_command_decoder.sv ----
// Command decoding and execution sequencing for the serial command channel
`timescale 1ns/1ps
`include "dscd_cfg.svh"
module disk_serial_command_decoder
  import dscd_pkg::*;
#(
  parameter int unsigned RECAL_CYCLES = `CLK_HZ / 1000 * `RECAL_MS,
  parameter int unsigned TRACK_OFS_CYCLES = `CLK_HZ / 1000 * `TRACK_OFS_MS,
  parameter int unsigned POWERUP_CYCLES = `CLK_HZ * `POWERUP_S,
  parameter int unsigned SEEK_CYCLES = `SEEK_CYCLES_DEF,
  parameter logic [15:0] FIXED_CYLINDERS = 16'h0400,
  parameter logic [7:0] HEAD_COUNT = 8'h05,
  parameter logic [7:0] DEFAULT_SECTORS = 8'h23,
  parameter logic [11:0] DEFAULT_BPS = 12'h254,
  // Arbitrary identification value
  parameter logic [15:0] VENDOR_ID = 16'h5A3C
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Serial command channel
  input wire logic transfer_req,
  input wire logic command_data,
  output logic transfer_ack,
  output logic config_status,
  output logic command_complete,
  output logic attention,
  // Straps and drive state
  input wire logic motor_option_strap,
  input wire logic sector_option_switch_a,
  input wire logic sector_option_switch_b,
  input wire logic sector_option_switch_c,
  input wire logic diag_fault,
  // Write path
  input wire logic write_gate,
  input wire logic address_mark_enable,
  output logic address_mark_write,
  output logic header_sync_start,
  // Mechanics control
  output logic spindle_run,
  output logic [11:0] seek_target,
  output logic [2:0] track_offset,
  output logic [1:0] strobe_offset,
  output logic [2:0] sector_option_sel
);
  logic [1:0] rst_sync_reg;
  logic rst_n;
  state_t state_reg;
  logic [31:0] timer_reg;
  logic [15:0] status_reg;
  logic att_pend_reg;
  logic straps_loaded_reg;
  logic motor_opt_reg;
  logic [7:0] sectors_reg;
  logic [11:0] bps_reg;
  logic [15:0] rem_reg;
  logic [7:0] quot_reg;
  logic [15:0] last_bad_reg;
  logic [2:0] wg_sync_reg;
  logic [2:0] ame_sync_reg;
  logic wg_level_reg;
  logic ame_level_reg;
  // Decode results
  logic dec_bad;
  logic dec_resp;
  logic [15:0] dec_resp_word;
  logic [31:0] dec_wait;
  logic dec_divide;
  logic dec_att;
  logic accept;
  logic [3:0] code;
  logic [3:0] modf;
  logic [15:0] st_set;
  logic [15:0] st_clr;

  cmd_shift_if lnk();

  cmd_word_receiver u_rx (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .transfer_req(transfer_req),
    .command_data(command_data),
    .transfer_ack(transfer_ack),
    .config_status(config_status),
    .lnk(lnk)
  );

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  function automatic logic word_allowed_stopped(input logic [15:0] w);
    logic ok;
    ok = (w == 16'h2000) || (w == 16'h3000) || (w == 16'h5000) || (w == 16'h5300);
    return ok || (w[15:12] == 4'h2 && w[7:0] == 8'h00);
  endfunction

  function automatic logic [15:0] config_word(input logic [3:0] m);
    logic [15:0] g;
    g = `GEN_CFG_BASE;
    g[`GEN_MOTOR_BIT] = motor_opt_reg;
    g[`GEN_SOFT_BIT] = sector_option_sel[0];
    g[`GEN_HARD_BIT] = ~sector_option_sel[0];
    unique case (m)
      4'h0: return g;
      4'h1: return FIXED_CYLINDERS;
      4'h2: return 16'h0000;
      4'h3: return {8'h00, HEAD_COUNT};
      4'h4: return `BYTES_PER_TRACK;
      // Derived from the current sector count, so it can differ from the value last set
      4'h5: return 16'(`BYTES_PER_TRACK / {8'h00, sectors_reg});
      4'h6: return {8'h00, sectors_reg};
      4'h7: return `ISG_WORD;
      4'h8: return `SYNC_WORD;
      4'h9: return `VU_COUNT_WORD;
      4'hF: return VENDOR_ID;
      default: return 16'h0000;
    endcase
  endfunction

  assign code = lnk.word[15:12];
  assign modf = lnk.word[11:8];
  assign accept = lnk.word_valid && (state_reg == ST_IDLE);

  always_comb
  begin
    dec_bad = 1'b0;
    dec_resp = 1'b0;
    dec_resp_word = 16'h0000;
    dec_wait = 32'd1;
    dec_divide = 1'b0;
    if (!lnk.parity_ok)
      dec_bad = 1'b1;
    else if (status_reg[`ST_SPIN_STOP] && !word_allowed_stopped(lnk.word))
      dec_bad = 1'b1;
    else
    begin
      unique case (code)
        CMD_SEEK: dec_wait = SEEK_CYCLES;
        CMD_RECAL: dec_wait = RECAL_CYCLES;
        CMD_STATUS:
        begin
          dec_resp = 1'b1;
          // Vendor words carry meaning only once the available bit is set
          if (modf == 4'h0)
            dec_resp_word = status_reg;
          else if (modf == 4'h1 && status_reg[`ST_VU_AVAIL])
            dec_resp_word = last_bad_reg;
          else
            dec_resp_word = {12'h000, modf & {4{status_reg[`ST_VU_AVAIL]}}};
        end
        CMD_CONFIG:
        begin
          if (modf >= `CFG_BAD_LO && modf <= `CFG_BAD_HI)
            dec_bad = 1'b1;
          else
          begin
            dec_resp = 1'b1;
            dec_resp_word = config_word(modf);
          end
        end
        CMD_CONTROL:
          dec_bad = !(modf == `CTL_RESET_ATT || (modf == `CTL_START_MOTOR && motor_opt_reg));
        CMD_STROBE_OFS: dec_wait = 32'd1;
        CMD_TRACK_OFS: dec_wait = TRACK_OFS_CYCLES;
        CMD_DIAG: dec_wait = 32'd1;
        CMD_SET_BPS:
        begin
          dec_bad = lnk.word[11:0] < `BPS_MIN;
          dec_divide = !dec_bad;
        end
        CMD_SET_CFG: dec_bad = (modf != `SOFT_SW_NUM);
        default: dec_bad = 1'b1;
      endcase
    end
    dec_att = dec_bad || (lnk.parity_ok && code == CMD_DIAG && diag_fault);
  end

  // Sequencer: complete falls on a taken word and rises when the work is done
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_POWERUP;
      timer_reg <= 32'd0;
      command_complete <= 1'b0;
      lnk.resp_load <= 1'b0;
      lnk.resp_word <= 16'h0000;
      rem_reg <= 16'h0000;
      quot_reg <= 8'h00;
    end
    else
    begin
      lnk.resp_load <= 1'b0;
      unique case (state_reg)
        ST_POWERUP:
        begin
          timer_reg <= timer_reg + 32'd1;
          if (timer_reg >= POWERUP_CYCLES - 1)
          begin
            command_complete <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        ST_IDLE:
        begin
          if (accept)
          begin
            command_complete <= 1'b0;
            if (!dec_bad && dec_resp)
            begin
              lnk.resp_load <= 1'b1;
              lnk.resp_word <= dec_resp_word;
              state_reg <= ST_SEND;
            end
            else if (!dec_bad && dec_divide)
            begin
              rem_reg <= `BYTES_PER_TRACK;
              quot_reg <= 8'h00;
              state_reg <= ST_DIVIDE;
            end
            else
            begin
              timer_reg <= dec_bad ? 32'd1 : dec_wait;
              state_reg <= ST_EXEC;
            end
          end
        end
        ST_EXEC:
        begin
          timer_reg <= timer_reg - 32'd1;
          if (timer_reg <= 32'd1)
          begin
            command_complete <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        ST_SEND:
        begin
          if (lnk.tx_done)
          begin
            command_complete <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        ST_DIVIDE:
        begin
          // Repeated subtraction; at most 254 rounds for the smallest sector
          if (rem_reg >= {4'h0, bps_reg})
          begin
            rem_reg <= rem_reg - {4'h0, bps_reg};
            quot_reg <= quot_reg + 8'h01;
          end
          else
          begin
            command_complete <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Sticky status: a new event wins over a same-cycle clear
  always_comb
  begin
    st_set = 16'h0000;
    st_clr = 16'h0000;
    if (accept)
    begin
      st_set[`ST_INVALID] = dec_bad && lnk.parity_ok;
      st_set[`ST_PARITY] = !lnk.parity_ok;
      st_set[`ST_DIAG] = dec_att && !dec_bad;
      st_set[`ST_VU_AVAIL] = dec_att && !dec_bad;
      if (!dec_bad && code == CMD_CONTROL && modf == `CTL_RESET_ATT)
        st_clr = `ST_CLEAR_MASK;
      if (!dec_bad && code == CMD_CONTROL && modf == `CTL_START_MOTOR)
        st_clr[`ST_SPIN_STOP] = 1'b1;
    end
    if (straps_loaded_reg == 1'b0)
      st_set[`ST_SPIN_STOP] = motor_option_strap;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_reg <= 16'h0000;
      att_pend_reg <= 1'b0;
      attention <= 1'b0;
      last_bad_reg <= 16'h0000;
    end
    else
    begin
      status_reg <= (status_reg & ~st_clr) | st_set;
      if (accept)
      begin
        att_pend_reg <= dec_att;
        if (dec_bad)
          last_bad_reg <= lnk.word;
        if (st_clr[0])
          attention <= 1'b0;
      end
      // Attention rises together with complete
      if (state_reg != ST_IDLE && state_reg != ST_POWERUP && att_pend_reg &&
          ((state_reg == ST_EXEC && timer_reg <= 32'd1) || (state_reg == ST_SEND && lnk.tx_done)))
      begin
        attention <= 1'b1;
        att_pend_reg <= 1'b0;
      end
    end
  end

  // Settings; soft switches fall back to straps after every reset
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      straps_loaded_reg <= 1'b0;
      motor_opt_reg <= 1'b0;
      sector_option_sel <= 3'h0;
      sectors_reg <= 8'h00;
      bps_reg <= 12'h000;
      spindle_run <= 1'b0;
      seek_target <= 12'h000;
      track_offset <= 3'h0;
      strobe_offset <= 2'h0;
    end
    else if (!straps_loaded_reg)
    begin
      straps_loaded_reg <= 1'b1;
      motor_opt_reg <= motor_option_strap;
      sector_option_sel <= {sector_option_switch_c, sector_option_switch_b, sector_option_switch_a};
      sectors_reg <= DEFAULT_SECTORS;
      bps_reg <= DEFAULT_BPS;
      spindle_run <= !motor_option_strap;
    end
    else
    begin
      if (accept && !dec_bad)
      begin
        unique case (code)
          CMD_SEEK: seek_target <= lnk.word[11:0];
          CMD_RECAL: seek_target <= 12'h000;
          CMD_CONTROL: if (modf == `CTL_START_MOTOR) spindle_run <= 1'b1;
          CMD_STROBE_OFS: strobe_offset <= modf[1:0];
          CMD_TRACK_OFS: track_offset <= modf[2:0];
          CMD_SET_BPS: bps_reg <= lnk.word[11:0];
          CMD_SET_CFG: sector_option_sel <= lnk.word[2:0];
          default: ;
        endcase
      end
      if (state_reg == ST_DIVIDE && rem_reg < {4'h0, bps_reg})
        sectors_reg <= quot_reg;
    end
  end

  // Write path pins pass three stages before use
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wg_sync_reg <= 3'h0;
      ame_sync_reg <= 3'h0;
      wg_level_reg <= 1'b0;
      ame_level_reg <= 1'b0;
      address_mark_write <= 1'b0;
      header_sync_start <= 1'b0;
    end
    else
    begin
      wg_sync_reg <= {wg_sync_reg[1:0], write_gate};
      ame_sync_reg <= {ame_sync_reg[1:0], address_mark_enable};
      if (wg_sync_reg[1] == wg_sync_reg[2])
        wg_level_reg <= wg_sync_reg[2];
      if (ame_sync_reg[1] == ame_sync_reg[2])
        ame_level_reg <= ame_sync_reg[2];
      address_mark_write <= ame_level_reg && wg_level_reg && sector_option_sel[0];
      header_sync_start <= !sector_option_sel[0] && wg_level_reg && ame_level_reg &&
                           (ame_sync_reg[1] == ame_sync_reg[2]) && !ame_sync_reg[2];
    end
  end
endmodule // disk_serial_command_decoder

// ---- test/dscd_checker.sv ----
// Port-level assertions for the serial command decoder
`timescale 1ns/1ps
module dscd_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Serial channel
  input wire logic transfer_req,
  input wire logic transfer_ack,
  input wire logic command_complete,
  input wire logic attention,
  // Write path and mechanics
  input wire logic address_mark_write,
  input wire logic header_sync_start,
  input wire logic spindle_run,
  input wire logic [11:0] seek_target,
  input wire logic [2:0] sector_option_sel
);
  logic ack_reg;
  logic [3:0] since_ack_reg;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // Saturating count of cycles since the acknowledge last moved
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ack_reg <= 1'b0;
      since_ack_reg <= 4'hF;
    end
    else
    begin
      ack_reg <= transfer_ack;
      if (transfer_ack != ack_reg)
        since_ack_reg <= 4'h0;
      else if (since_ack_reg != 4'hF)
        since_ack_reg <= since_ack_reg + 4'h1;
    end
  end
  a_ack_follows_req: assert property ($changed(transfer_req) |-> ##[2:7] transfer_ack == transfer_req)
    else $error("ack late");
  a_ack_toward_req: assert property ($changed(transfer_ack) |-> transfer_ack == transfer_req)
    else $error("ack moved alone");
  a_decode_after_word: assert property ($fell(command_complete) |-> since_ack_reg <= 4'h3)
    else $error("complete fell without a bit");
  a_attention_with_done: assert property ($rose(attention) |-> command_complete)
    else $error("attention without complete");
  a_no_mark_fixed: assert property ((!sector_option_sel[0]) [*3] |-> !address_mark_write)
    else $error("mark in fixed mode");
  a_sync_one_cycle: assert property (header_sync_start |=> !header_sync_start)
    else $error("sync pulse long");
  a_sync_fixed_only: assert property (header_sync_start |-> !sector_option_sel[0])
    else $error("sync in soft mode");
  a_seek_while_busy: assert property ($changed(seek_target) |-> !command_complete)
    else $error("target moved while idle");
  c_attention: cover property ($rose(attention));
  c_sync: cover property (header_sync_start);
  c_spin: cover property ($rose(spindle_run));
endmodule // dscd_checker
bind disk_serial_command_decoder dscd_checker u_dscd_checker (.core_clk, .arst_n, .transfer_req, .transfer_ack,
  .command_complete, .attention, .address_mark_write, .header_sync_start, .spindle_run, .seek_target,
  .sector_option_sel);

// ---- test/dscd_ctl_model.sv ----
// Behavioural disk controller driving the serial command channel
`timescale 1ns/1ps
module dscd_ctl_model (
  // Clock
  input wire logic core_clk,
  // Drive answers
  input wire logic transfer_ack,
  input wire logic config_status,
  // Controller pins
  output logic transfer_req,
  output logic command_data,
  // Handshakes that never completed
  output int stalls
);
  initial
  begin
    transfer_req = 1'b0;
    command_data = 1'b1;
    stalls = 0;
  end
  // Data settles a cycle ahead of the request edge and holds until the acknowledge matches
  task automatic edge_bit(input logic b, input int slow, output logic got);
    int n = 0;
    @(negedge core_clk);
    command_data = b;
    @(negedge core_clk);
    transfer_req = ~transfer_req;
    while (transfer_ack !== transfer_req && n < 40)
    begin
      @(negedge core_clk);
      n++;
    end
    got = config_status;
    if (n >= 40)
      stalls++;
    repeat (slow) @(negedge core_clk);
    // Released line shows the inverse so a stale bit never reads as fresh
    @(negedge core_clk);
    command_data = ~b;
  endtask
  task automatic xfer(input logic [15:0] w, input bit resp, input int slow, output logic [16:0] r);
    logic [16:0] f;
    logic g;
    f = {w, ~^w};
    for (int i = 16; i >= 0; i--)
      edge_bit(f[i], slow, g);
    r = 17'h0;
    if (resp)
      for (int i = 16; i >= 0; i--)
        edge_bit(~f[i], slow, r[i]);
  endtask
endmodule // dscd_ctl_model

// ---- test/disk_serial_command_decoder_tb_top.sv ----
// Self-checking bench for the serial command decoder
`timescale 1ns/1ps
`include "dscd_cfg.svh"
module disk_serial_command_decoder_tb_top;
  localparam int SEEK_C = 10;
  localparam int RECAL_C = 50;
  localparam int TRK_C = 30;
  // Arbitrary identification value
  localparam logic [15:0] VID = 16'hC3A5;
  logic core_clk, arst_n, transfer_req, command_data, transfer_ack, config_status, command_complete, attention;
  logic motor_option_strap, sector_option_switch_a, sector_option_switch_b, sector_option_switch_c, diag_fault;
  logic write_gate, address_mark_enable, address_mark_write, header_sync_start, spindle_run;
  logic [11:0] seek_target;
  logic [2:0] track_offset, sector_option_sel;
  logic [1:0] strobe_offset;
  logic [16:0] rsp;
  logic [3:0] rc [6] = '{4'h4, 4'hA, 4'hB, 4'hC, 4'hD, 4'hF};
  int errors, n_compared, stalls, cycles, busy, sectors, sel, p, pulses;
  disk_serial_command_decoder #(.RECAL_CYCLES(RECAL_C), .TRACK_OFS_CYCLES(TRK_C), .POWERUP_CYCLES(20),
    .SEEK_CYCLES(SEEK_C), .VENDOR_ID(VID)) dut (.core_clk, .arst_n, .transfer_req, .command_data, .transfer_ack,
    .config_status, .command_complete, .attention, .motor_option_strap, .sector_option_switch_a,
    .sector_option_switch_b, .sector_option_switch_c, .diag_fault, .write_gate, .address_mark_enable,
    .address_mark_write, .header_sync_start, .spindle_run, .seek_target, .track_offset, .strobe_offset,
    .sector_option_sel);
  dscd_ctl_model u_ctl (.core_clk, .transfer_ack, .config_status, .transfer_req, .command_data, .stalls);
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      errors++;
      $display("FAIL run_time expected 90000 seen %0d", cycles);
      end_of_test();
    end
  end
  task automatic end_of_test();
    errors += stalls;
    $display("Compared %0d, errors %0d, stalls %0d", n_compared, errors, stalls);
    if (errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_cc();
    int n = 0;
    while (command_complete !== 1'b1 && n < 400)
    begin
      @(negedge core_clk);
      n++;
    end
    busy += n;
    chk("complete_wait", 1, n < 400);
  endtask
  task automatic cmd(input logic [15:0] w, input bit resp);
    wait_cc();
    u_ctl.xfer(w, resp, $urandom_range(0, 2), rsp);
    busy = 0;
    if (!resp)
    begin
      repeat (3) @(posedge core_clk);
      busy = 3;
    end
    wait_cc();
    if (resp)
      chk("resp_parity", 1, ^rsp);
  endtask
  task automatic bad_word(input logic [15:0] w);
    cmd(w, 0);
    chk("attention", 1, attention);
    cmd(16'h2000, 1);
    chk("invalid_bit", 1, rsp[1]);
    cmd(16'h5000, 0);
    chk("attention_clear", 0, attention);
  endtask
  function automatic logic [15:0] cfg_exp(input int m);
    logic [15:0] t [16];
    t = '{`GEN_CFG_BASE | 16'h0020 | (sel[0] ? 16'h0004 : 16'h0002), 16'h0400, 16'h0000, 16'h0005,
      `BYTES_PER_TRACK, 16'(20880 / sectors), 16'(sectors), `ISG_WORD, `SYNC_WORD, `VU_COUNT_WORD,
      16'h0, 16'h0, 16'h0, 16'h0, 16'h0, VID};
    return t[m];
  endfunction
  initial
  begin
    {core_clk, arst_n, diag_fault, write_gate, address_mark_enable, sector_option_switch_b} = 6'h00;
    {motor_option_strap, sector_option_switch_a, sector_option_switch_c} = 3'h7;
    {errors, n_compared, cycles, busy} = 0;
    sectors = 35;
    sel = 5;
    p = $urandom(32'h4296);
    repeat (12) @(negedge core_clk);
    arst_n = 1'b1;
    wait_cc();
    chk("strap_spindle", 0, spindle_run);
    chk("strap_switch", sel, sector_option_sel);
    bad_word(16'h0123);
    cmd(16'h2000, 1);
    chk("status", 16'h1000, rsp[16:1] & 16'h100B);
    cmd({4'h2, 4'($urandom_range(1, 15)), 8'h00}, 1);
    chk("vendor_word", 0, rsp[16:1]);
    cmd(16'h3000, 1);
    chk("gen_cfg", cfg_exp(0), rsp[16:1]);
    cmd(16'h5300, 0);
    chk("spindle_run", 1, spindle_run);
    cmd(16'h2000, 1);
    chk("status_run", 16'h0000, rsp[16:1] & 16'h100B);
    for (int m = 0; m < 16; m++)
      if (m inside {[10:14]})
        bad_word({4'h3, 4'(m), 8'h00});
      else
      begin
        cmd({4'h3, 4'(m), 8'h00}, 1);
        chk("cfg_word", cfg_exp(m), rsp[16:1]);
      end
    for (int m = 1; m < 16; m++)
      if (m != 3)
        bad_word({4'h5, 4'(m), 8'h00});
    foreach (rc[i])
      bad_word({rc[i], 12'($urandom)});
    bad_word(16'h9000);
    bad_word(16'h9051);
    for (int i = 0; i < 3; i++)
    begin
      p = (i == 0) ? 82 : (i == 1) ? $urandom_range(83, 4094) : 4095;
      cmd({4'h9, 12'(p)}, 0);
      chk("bps_att", 0, attention);
      sectors = 20880 / p;
      for (int m = 5; m < 7; m++)
      begin
        cmd({4'h3, 4'(m), 8'h00}, 1);
        chk("bps_cfg", cfg_exp(m), rsp[16:1]);
      end
    end
    for (int f = 0; f < 2; f++)
    begin
      @(negedge core_clk);
      diag_fault = f[0];
      cmd(16'h8000, 0);
      chk("diag_att", 16'(f), attention);
    end
    cmd(16'h2000, 1);
    chk("diag_bit", 1, rsp[4]);
    for (int i = 0; i < 3; i++)
    begin
      cmd(16'h5000, 0);
      cmd(16'h8000, 0);
      chk("retry_att", 1, attention);
    end
    cmd(16'h2100, 1);
    chk("vendor_last", 16'h9051, rsp[16:1]);
    @(negedge core_clk);
    diag_fault = 1'b0;
    cmd(16'h5000, 0);
    p = $urandom_range(1, 4095);
    cmd({4'h0, 12'(p)}, 0);
    chk("seek_target", 16'(p), seek_target);
    chk("seek_time", 1, busy >= SEEK_C - 2);
    cmd(16'h1000, 0);
    chk("recal_target", 0, seek_target);
    chk("recal_time", 1, busy >= RECAL_C - 2 && busy <= RECAL_C + 12);
    for (int m = 0; m < 16; m++)
    begin
      cmd({4'h7, 4'(m), 8'h00}, 0);
      chk("track_offset", 16'(m % 8), track_offset);
      chk("track_time", 1, busy <= TRK_C + 12 && attention === 1'b0);
      cmd({4'h6, 4'(m), 8'h00}, 0);
      chk("strobe_offset", 16'(m % 4), {attention, strobe_offset});
    end
    for (int i = 0; i < 2; i++)
    begin
      sel = i ? 7 : 2 * $urandom_range(0, 3);
      cmd({8'hE1, 8'(sel)}, 0);
      chk("switch_sel", 16'(sel), sector_option_sel);
      cmd(16'h3000, 1);
      chk("gen_cfg_soft", cfg_exp(0), rsp[16:1]);
      @(negedge core_clk);
      write_gate = 1'b1;
      address_mark_enable = 1'b1;
      repeat (8) @(negedge core_clk);
      chk("mark_write", 16'(i), address_mark_write);
      pulses = 0;
      address_mark_enable = 1'b0;
      repeat (10)
      begin
        @(negedge core_clk);
        pulses += int'(header_sync_start);
      end
      chk("sync_pulses", 16'(1 - i), 16'(pulses));
      write_gate = 1'b0;
    end
    @(negedge core_clk);
    arst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    arst_n = 1'b1;
    sel = 5;
    wait_cc();
    chk("switch_restore", 16'(sel), sector_option_sel);
    chk("spindle_restart", 0, spindle_run);
    end_of_test();
  end
endmodule // disk_serial_command_decoder_tb_top
